// file: dv/pdl_mgmt_model.sv
`timescale 1ns/100ps
module pdl_mgmt_model
  import pdl_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic [15:0] reg_rdata_in,
  output logic      [4:0]  reg_addr_out,
  output logic             reg_wr_out,
  output logic             reg_rd_out,
  output logic      [15:0] reg_wdata_out
);
  initial begin
    reg_addr_out  = 5'h1f;
    reg_wr_out    = 1'b0;
    reg_rd_out    = 1'b0;
    reg_wdata_out = 16'hffff;
  end

  // Strobe for one taking edge, then scramble the idle bus
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge core_clk_in);
    reg_addr_out  <= a;
    reg_wdata_out <= v;
    reg_wr_out    <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_out    <= 1'b0;
    reg_addr_out  <= ~a;
    reg_wdata_out <= ~v;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(posedge core_clk_in);
    reg_addr_out <= a;
    reg_rd_out   <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_out   <= 1'b0;
    reg_addr_out <= ~a;
    #1;
    v = reg_rdata_in;
  endtask : rd
endmodule : pdl_mgmt_model

// file: dv/pdl_mode_status_monitor.sv
`timescale 1ns/100ps
module pdl_mode_status_monitor
  import pdl_pkg::*;
(
  input wire logic        core_clk_in,
  input wire logic        rst_in,
  input wire logic [4:0]  reg_addr_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic [15:0] reg_rdata_out,
  input wire pdl_mii_s    mii_tx_in,
  input wire pdl_mii_s    line_rx_in,
  input wire logic        line_col_in,
  input wire logic        mii_crs_out,
  input wire logic        mii_col_out,
  input wire logic        powerdown_or_irq_pin_in,
  input wire logic        powerdown_or_irq_pin_out,
  input wire logic        powerdown_or_irq_pin_oe_out,
  input wire logic        power_down_out,
  input wire logic        ed_pulse_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_pin_held_low;
    (!powerdown_or_irq_pin_oe_out && !powerdown_or_irq_pin_in) [*4];
  endsequence
  sequence s_rd_hole;
    reg_rd_in && reg_addr_in == 5'h07;
  endsequence

  a_crs_has_cause: assert property (
    mii_crs_out |-> $past(mii_tx_in.en || line_rx_in.en))
    else $error("carrier without activity");
  a_col_has_cause: assert property (
    mii_col_out |-> $past(line_col_in))
    else $error("collision without line collision");
  a_pin_forces_pdn: assert property (
    s_pin_held_low |-> power_down_out)
    else $error("pin low did not power down");
  a_reset_pin_idle: assert property (
    $past(rst_in) |-> powerdown_or_irq_pin_out && !powerdown_or_irq_pin_oe_out)
    else $error("pin not idle after reset");
  a_pulse_one_cycle: assert property (
    ed_pulse_out |=> !ed_pulse_out)
    else $error("energy pulse longer than one cycle");
  a_rdata_holds: assert property (
    !$past(reg_rd_in) |-> $stable(reg_rdata_out))
    else $error("read data moved without a read");
  a_oe_follows_write: assert property (
    reg_wr_in && reg_addr_in == ADDR_ICTL
      |-> ##2 powerdown_or_irq_pin_oe_out == $past(reg_wdata_in[ICTL_OE], 2))
    else $error("pin enable not taken from control write");
  a_hole_reads_zero: assert property (
    s_rd_hole |=> reg_rdata_out == 16'h0000)
    else $error("unmapped index read nonzero");
endmodule : pdl_mode_status_monitor

bind pdl_mode_status pdl_mode_status_monitor pdl_mode_status_monitor_i (.*);

// file: dv/pdl_mode_status_tb.sv
`timescale 1ns/100ps
module pdl_mode_status_tb;
  import pdl_pkg::*;
  logic        core_clk_in, rst_in, reg_wr_in, reg_rd_in, line_col_in, strap_fiber_in;
  logic        negotiation_ability_strap_a_in, negotiation_ability_strap_b_in, pin_ext;
  logic        negotiation_enable_strap_in, powerdown_or_irq_pin_in, mii_crs_out, mii_col_out;
  logic        mii_oe_out, powerdown_or_irq_pin_out, powerdown_or_irq_pin_oe_out;
  logic        power_down_out, ed_low_power_out, ed_pulse_out;
  logic [4:0]  reg_addr_in;
  logic [7:0]  var_sample_in;
  logic [15:0] reg_wdata_in, reg_rdata_out, d;
  pdl_mii_s    mii_tx_in, line_rx_in, mii_rx_out, media_tx_out;
  pdl_line_s   line_in;
  int          error_cnt, num_checks;

  pdl_mode_status #(.VAR_STEP(300), .ED_PERIOD(8)) pdl_mode_status_i (.*);
  pdl_mgmt_model pdl_mgmt_model_i (
    .core_clk_in   (core_clk_in),
    .reg_rdata_in  (reg_rdata_out),
    .reg_addr_out  (reg_addr_in),
    .reg_wr_out    (reg_wr_in),
    .reg_rd_out    (reg_rd_in),
    .reg_wdata_out (reg_wdata_in)
  );
  // Pull-up unless the pin drives or an outside source pulls low
  assign powerdown_or_irq_pin_in = powerdown_or_irq_pin_oe_out ? powerdown_or_irq_pin_out : pin_ext;

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  task automatic results;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : tick

  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    pdl_mgmt_model_i.wr(a, v);
  endtask : wr

  task automatic rb(input string n, input logic [4:0] a, input logic [15:0] m, logic [15:0] e);
    pdl_mgmt_model_i.rd(a, d);
    chk(n, d & m, e);
  endtask : rb

  task automatic do_reset(input logic f, input logic a, input logic b);
    @(posedge core_clk_in);
    rst_in <= 1'b1;
    strap_fiber_in <= f;
    negotiation_ability_strap_a_in <= a;
    negotiation_ability_strap_b_in <= b;
    repeat (6) @(posedge core_clk_in);
    rst_in <= 1'b0;
    tick(3);
  endtask : do_reset

  task automatic drive(input pdl_mii_s t, input pdl_mii_s r, input logic c);
    @(posedge core_clk_in);
    mii_tx_in <= t;
    line_rx_in <= r;
    line_col_in <= c;
    tick(2);
  endtask : drive

  task automatic wait_pin(input logic v);
    for (int i = 0; i < 20 && powerdown_or_irq_pin_out !== v; i++) tick(1);
    if (powerdown_or_irq_pin_out !== v) begin
      chk("pin_wait", powerdown_or_irq_pin_out, v);
      results();
    end
  endtask : wait_pin

  task automatic t_reset;
    rb("bmc", ADDR_BMC, 16'hffff, 16'h3100);
    rb("ictl", ADDR_ICTL, 16'hffff, 16'h0000);
    rb("ims_rst", ADDR_IMS, 16'hffff, 16'h0000);
    rb("hole", 5'h07, 16'hffff, 16'h0000);
    chk("pin", {powerdown_or_irq_pin_oe_out, powerdown_or_irq_pin_out}, 16'h0001);
  endtask : t_reset

  task automatic t_duplex;
    wr(ADDR_BMC, 16'h2000);
    drive(6'h2a, 6'h00, 1'b1);
    chk("crs_half", mii_crs_out, 1'b1);
    chk("col_half", mii_col_out, 1'b1);
    drive(6'h00, 6'h29, 1'b0);
    chk("rx_half", mii_rx_out, 6'h29);
    wr(ADDR_BMC, 16'h2100);
    drive(6'h2a, 6'h00, 1'b1);
    chk("crs_full", mii_crs_out, 1'b0);
    chk("col_full", mii_col_out, 1'b0);
    chk("media", media_tx_out, 6'h2a);
  endtask : t_duplex

  task automatic t_loop;
    wr(ADDR_BMC, 16'h6100);
    tick(3);
    chk("loop_rx", mii_rx_out, 6'h2a);
    chk("loop_media", media_tx_out.en, 1'b0);
    rb("sts_loop", ADDR_STS, 16'h0008, 16'h0008);
    wr(ADDR_BMC, 16'h2500);
    tick(3);
    chk("iso_oe", mii_oe_out, 1'b0);
    chk("iso_media", media_tx_out.en, 1'b0);
    wr(ADDR_BMC, 16'h2100);
    tick(3);
    chk("run_oe", mii_oe_out, 1'b1);
    rb("sts_run", ADDR_STS, 16'h0008, 16'h0000);
  endtask : t_loop

  task automatic t_pwr;
    @(posedge core_clk_in);
    pin_ext <= 1'b0;
    tick(6);
    chk("pdn", power_down_out, 1'b1);
    rb("bmc_pdn", ADDR_BMC, 16'h0100, 16'h0100);
    wr(ADDR_ICTL, 16'h0001);
    tick(4);
    chk("pdn_exit", power_down_out, 1'b0);
    @(posedge core_clk_in);
    pin_ext <= 1'b1;
  endtask : t_pwr

  task automatic t_irq;
    pdl_mgmt_model_i.rd(ADDR_IMS, d);
    wr(ADDR_ICTL, 16'h0003);
    wr(ADDR_IMS, 16'h0060);
    rb("ims_clr", ADDR_IMS, 16'hffff, 16'h0060);
    @(posedge core_clk_in);
    line_in.link_up <= 1'b0;
    wait_pin(1'b0);
    rb("ims_link", ADDR_IMS, 16'hffff, 16'h2060);
    tick(2);
    chk("pin_rel", powerdown_or_irq_pin_out, 1'b1);
    @(posedge core_clk_in);
    line_in.speed_100 <= 1'b0;
    tick(8);
    chk("masked", powerdown_or_irq_pin_out, 1'b1);
    @(posedge core_clk_in);
    line_in.link_up <= 1'b1;
    line_in.speed_100 <= 1'b1;
    wait_pin(1'b0);
    wr(ADDR_ICTL, 16'h0001);
    tick(3);
    chk("irq_off", powerdown_or_irq_pin_out, 1'b1);
    pdl_mgmt_model_i.rd(ADDR_IMS, d);
  endtask : t_irq

  task automatic t_diag;
    @(posedge core_clk_in);
    line_in.speed_100 <= 1'b0;
    rb("sts_diag", ADDR_STS, 16'h5000, 16'h5000);
    rb("ten_pol", ADDR_TENSC, 16'h0010, 16'h0010);
    @(posedge core_clk_in);
    line_in.speed_100 <= 1'b1;
    rb("sts_fpol", ADDR_STS, 16'h1000, 16'h0000);
    rb("len_p0", ADDR_CLEN, 16'hffff, 16'h0000);
    wr(ADDR_PAGE, 16'h0002);
    rb("len_p2", ADDR_CLEN, 16'hffff, 16'h0123);
    rb("freq_off", ADDR_FREQ, 16'h00ff, 16'h005a);
    wr(ADDR_FREQ, 16'h0100);
    rb("freq_ctl", ADDR_FREQ, 16'h00ff, 16'h00a5);
    wr(ADDR_PAGE, 16'h0000);
  endtask : t_diag

  task automatic t_energy;
    int p;
    logic lp;
    p = 0;
    lp = 1'b0;
    wr(ADDR_EDC, 16'h8000);
    line_in.energy <= 1'b0;
    for (int i = 0; i < 30; i++) begin
      tick(1);
      p += int'(ed_pulse_out === 1'b1);
      lp |= ed_low_power_out;
    end
    chk("ed_low", lp, 1'b1);
    chk("ed_pulse", 16'(p > 1), 16'h0001);
    @(posedge core_clk_in);
    line_in.energy <= 1'b1;
    tick(6);
    chk("ed_wake", ed_low_power_out, 1'b0);
  endtask : t_energy

  // Window 1200 cycles of 0xff samples: 1200 * 255 = 0004ab50h
  task automatic t_var;
    @(posedge core_clk_in);
    var_sample_in <= 8'hff;
    wr(ADDR_PAGE, 16'h0002);
    wr(ADDR_VCTL, 16'h8006);
    rb("vctl", ADDR_VCTL, 16'hffff, 16'h8006);
    tick(2420);
    rb("var_lo", ADDR_VDAT, 16'hffff, 16'hab50);
    @(posedge core_clk_in);
    var_sample_in <= 8'h00;
    tick(2420);
    rb("var_hi", ADDR_VDAT, 16'hffff, 16'h0004);
    wr(ADDR_PAGE, 16'h0000);
  endtask : t_var

  task automatic t_fiber;
    do_reset(1'b1, 1'b1, 1'b0);
    rb("fib_bmc", ADDR_BMC, 16'hffff, 16'h2100);
    wr(ADDR_BMC, 16'h3100);
    rb("fib_an", ADDR_BMC, 16'h1100, 16'h0100);
  endtask : t_fiber

  initial begin
    rst_in = 1'b1;
    strap_fiber_in = 1'b0;
    negotiation_ability_strap_a_in = 1'b0;
    negotiation_ability_strap_b_in = 1'b1;
    negotiation_enable_strap_in = 1'b1;
    pin_ext = 1'b1;
    line_col_in = 1'b0;
    mii_tx_in = '0;
    line_rx_in = '0;
    var_sample_in = 8'h03;
    line_in = {7'b1100111, 16'h0123, 8'h5a, 8'ha5};
    error_cnt = 0;
    num_checks = 0;
    do_reset(1'b0, 1'b0, 1'b1);
    t_reset();
    t_duplex();
    t_loop();
    t_pwr();
    t_irq();
    t_diag();
    t_energy();
    t_var();
    t_fiber();
    results();
  end
endmodule : pdl_mode_status_tb

// file: src/pdl_mode_status.sv
`timescale 1ns/100ps
// What this block does
// - Half duplex: carrier on transmit or receive
// - Full duplex: no collision, carrier from receive (transmit in loopback)
// - Other MII signals independent of duplex
// - Control bit 8 selects duplex when forced
// - Fiber strap loads duplex from ability strap
// - Loopback routes transmit to receive, media silent
// - Loopback state shown in status bit 3
// - Shared pin input by default, OE makes output
// - Pin low as input forces power-down
// - Registers served in power-down; OE exits pin power-down
// - Interrupts off at reset, enable and mask gate
// - Pin driven low on enabled interrupt
// - Status read shows and clears pending sources
// - 0003h and 0060h writes enable link/energy
// - Energy detect low power, wake, pulse
// - Diagnostic page only when selected
// - Polarity in status bit 12 and 10Mb bit 4
// - Crossover state in status bit 14
// - Cable length valid at 100Mb link only
// - Frequency report offset or control value
// - Variance 32-bit sum, selectable window
// - Isolate ignores transmit, tri-states MII
module pdl_mode_status
  import pdl_pkg::*;
#(
  parameter int VAR_STEP = VAR_STEP_CYCLES,
  parameter int ED_PERIOD = ED_PULSE_CYCLES
) (
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic [4:0]  reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [15:0] reg_wdata_in,
  output logic      [15:0] reg_rdata_out,
  input  wire logic        strap_fiber_in,
  input  wire logic        negotiation_ability_strap_a_in,
  input  wire logic        negotiation_ability_strap_b_in,
  input  wire logic        negotiation_enable_strap_in,
  input  wire pdl_mii_s    mii_tx_in,
  input  wire pdl_mii_s    line_rx_in,
  input  wire logic        line_col_in,
  input  wire pdl_line_s   line_in,
  input  wire logic [7:0]  var_sample_in,
  output pdl_mii_s         mii_rx_out,
  output logic             mii_crs_out,
  output logic             mii_col_out,
  output logic             mii_oe_out,
  output pdl_mii_s         media_tx_out,
  input  wire logic        powerdown_or_irq_pin_in,
  output logic             powerdown_or_irq_pin_out,
  output logic             powerdown_or_irq_pin_oe_out,
  output logic             power_down_out,
  output logic             ed_low_power_out,
  output logic             ed_pulse_out
);

  logic [15:0] basic_mode_control_reg;
  logic [15:0] interrupt_control_reg;
  logic [7:0]  irq_mask_reg;
  logic [7:0]  irq_pend_reg;
  logic [7:0]  irq_pend_next;
  logic [2:0]  register_page_select_reg;
  logic [15:0] energy_detect_control_reg;
  logic [15:0] variance_control_reg;
  logic [15:0] freq_sel_reg;
  logic        strap_load_reg;
  logic        fiber_reg;
  logic [15:0] rdata_next;
  logic        diag_page;
  logic        full_duplex;
  logic        diag_valid;
  logic        pin_pdn;
  logic        pdn;
  logic        irq;
  logic [3:0]  prev_reg;
  logic        evt_arm_reg;
  logic [3:0]  now_state;
  logic [31:0] var_acc_reg;
  logic [31:0] var_sum_reg;
  logic [31:0] var_snap_reg;
  logic        var_half_reg;
  logic [31:0] var_cnt_reg;
  logic [31:0] var_win;
  logic [31:0] ed_cnt_reg;
  logic        ed_low;
  logic [15:0] sts_word;

  // forced duplex unless negotiation resolved it (never in fiber)
  assign full_duplex = (basic_mode_control_reg[BMC_NEGOTIATION_ENABLE_STRAP] && !fiber_reg && line_in.an_done)
                       ? line_in.an_full : basic_mode_control_reg[BMC_DUPLEX];
  assign diag_page   = (register_page_select_reg == DIAG_PAGE);
  assign diag_valid  = line_in.speed_100 && line_in.link_up;
  // pin low only counts while it is an input
  assign pin_pdn     = !interrupt_control_reg[ICTL_OE] && !powerdown_or_irq_pin_in;
  assign pdn         = basic_mode_control_reg[BMC_PDN] || pin_pdn;
  assign ed_low      = energy_detect_control_reg[EDC_EN] && !line_in.energy;
  assign irq         = interrupt_control_reg[ICTL_EN] && |(irq_pend_reg & irq_mask_reg);
  assign var_win     = VAR_STEP * (32'(variance_control_reg[VCTL_T_LSB +: 2]) + 32'h1);
  assign now_state   = {ed_low, line_in.link_up, full_duplex, line_in.speed_100};

  always_comb begin
    sts_word = 16'h0;
    sts_word[STS_LINK]   = line_in.link_up;
    sts_word[STS_SPD10]  = !line_in.speed_100;
    sts_word[STS_DUPLEX] = full_duplex;
    sts_word[STS_LOOP]   = basic_mode_control_reg[BMC_LOOP];
    // polarity valid at 10Mb or negotiated 100Mb
    sts_word[STS_POL]    = line_in.pol_inv && (!line_in.speed_100 || line_in.an_done);
    sts_word[STS_MDIX]   = line_in.mdix;
  end

  // Strap capture after reset release
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      strap_load_reg <= 1'b1;
      fiber_reg      <= 1'b0;
    end else begin
      strap_load_reg <= 1'b0;
      if (strap_load_reg) begin
        fiber_reg <= strap_fiber_in;
      end
    end
  end

  // Basic mode control
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      basic_mode_control_reg <= BMC_RESET;
    end else if (strap_load_reg) begin
      // fiber: duplex from strap a, no negotiation
      if (strap_fiber_in) begin
        basic_mode_control_reg[BMC_NEGOTIATION_ENABLE_STRAP]  <= 1'b0;
        basic_mode_control_reg[BMC_DUPLEX] <= negotiation_ability_strap_a_in;
      end else begin
        basic_mode_control_reg[BMC_NEGOTIATION_ENABLE_STRAP]  <= negotiation_enable_strap_in;
        basic_mode_control_reg[BMC_DUPLEX] <= negotiation_ability_strap_b_in;
      end
    end else if (reg_wr_in && reg_addr_in == ADDR_BMC) begin
      basic_mode_control_reg <= reg_wdata_in;
      if (fiber_reg) begin
        basic_mode_control_reg[BMC_NEGOTIATION_ENABLE_STRAP] <= 1'b0;
      end
    end
  end

  // Interrupt control, mask, page, energy detect
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      interrupt_control_reg     <= 16'h0;
      irq_mask_reg              <= 8'h0;
      register_page_select_reg  <= 3'h0;
      energy_detect_control_reg <= 16'h0;
      variance_control_reg      <= 16'h0;
      freq_sel_reg              <= 16'h0;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        // output enable and interrupt enable bits
        ADDR_ICTL: begin
          interrupt_control_reg[ICTL_OE] <= reg_wdata_in[ICTL_OE];
          interrupt_control_reg[ICTL_EN] <= reg_wdata_in[ICTL_EN];
        end
        // low byte holds the source mask
        ADDR_IMS:  irq_mask_reg <= reg_wdata_in[7:0];
        ADDR_PAGE: register_page_select_reg <= reg_wdata_in[2:0];
        default: begin
          if (diag_page && reg_addr_in == ADDR_VCTL) begin
            variance_control_reg <= reg_wdata_in;
          end
          if (diag_page && reg_addr_in == ADDR_FREQ) begin
            freq_sel_reg <= reg_wdata_in;
          end
          if (!diag_page && reg_addr_in == ADDR_EDC) begin
            energy_detect_control_reg <= reg_wdata_in;
          end
        end
      endcase
    end
  end

  // clear on read; a same-cycle event still sets
  always_comb begin
    irq_pend_next = irq_pend_reg;
    if (reg_rd_in && reg_addr_in == ADDR_IMS) begin
      irq_pend_next = 8'h0;
    end
    // Settling from reset and strap load is no event
    if (evt_arm_reg) begin
      irq_pend_next[SRC_SPEED]  = irq_pend_next[SRC_SPEED]  | (prev_reg[0] ^ now_state[0]);
      irq_pend_next[SRC_DUPLEX] = irq_pend_next[SRC_DUPLEX] | (prev_reg[1] ^ now_state[1]);
      irq_pend_next[SRC_LINK]   = irq_pend_next[SRC_LINK]   | (prev_reg[2] ^ now_state[2]);
      irq_pend_next[SRC_ENERGY] = irq_pend_next[SRC_ENERGY] | (prev_reg[3] ^ now_state[3]);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      irq_pend_reg <= 8'h0;
      prev_reg     <= 4'h0;
      evt_arm_reg  <= 1'b0;
    end else begin
      irq_pend_reg <= irq_pend_next;
      prev_reg     <= now_state;
      evt_arm_reg  <= !strap_load_reg;
    end
  end

  // shared pin: driven low on interrupt once output enabled
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      powerdown_or_irq_pin_oe_out <= 1'b0;
      powerdown_or_irq_pin_out    <= 1'b1;
      power_down_out              <= 1'b0;
    end else begin
      powerdown_or_irq_pin_oe_out <= interrupt_control_reg[ICTL_OE];
      powerdown_or_irq_pin_out    <= !irq;
      // pin or control bit powers down
      power_down_out              <= pdn;
    end
  end

  // energy detect state and periodic pulses
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ed_cnt_reg       <= 32'h0;
      ed_low_power_out <= 1'b0;
      ed_pulse_out     <= 1'b0;
    end else begin
      ed_low_power_out <= ed_low;
      ed_pulse_out     <= 1'b0;
      if (!energy_detect_control_reg[EDC_EN]) begin
        ed_cnt_reg <= 32'h0;
      end else if (ed_cnt_reg == 32'(ED_PERIOD - 1)) begin
        ed_cnt_reg   <= 32'h0;
        ed_pulse_out <= 1'b1;
      end else begin
        ed_cnt_reg <= ed_cnt_reg + 32'h1;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      var_acc_reg <= 32'h0;
      var_cnt_reg <= 32'h0;
      var_sum_reg <= 32'h0;
    end else if (!variance_control_reg[VCTL_EN] || !diag_valid) begin
      var_acc_reg <= 32'h0;
      var_cnt_reg <= 32'h0;
    end else if (var_cnt_reg == var_win - 32'h1) begin
      var_sum_reg <= var_acc_reg + 32'(var_sample_in);
      var_acc_reg <= 32'h0;
      var_cnt_reg <= 32'h0;
    end else begin
      var_acc_reg <= var_acc_reg + 32'(var_sample_in);
      var_cnt_reg <= var_cnt_reg + 32'h1;
    end
  end

  // first read snapshots the sum, second returns upper half
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      var_half_reg <= 1'b0;
      var_snap_reg <= 32'h0;
    end else if (reg_rd_in && diag_page && reg_addr_in == ADDR_VDAT) begin
      var_half_reg <= !var_half_reg;
      if (!var_half_reg) begin
        var_snap_reg <= var_sum_reg;
      end
    end
  end

  // diagnostic registers only on the selected page
  always_comb begin
    rdata_next = 16'h0;
    case (reg_addr_in)
      ADDR_BMC:  rdata_next = basic_mode_control_reg;
      ADDR_STS:  rdata_next = sts_word;
      ADDR_ICTL: rdata_next = interrupt_control_reg;
      // pending sources in the upper byte
      ADDR_IMS:  rdata_next = {irq_pend_reg, irq_mask_reg};
      ADDR_PAGE: rdata_next = {13'h0, register_page_select_reg};
      ADDR_CLEN: begin
        if (diag_page && diag_valid) begin
          rdata_next = line_in.cable_len;
        end
      end
      ADDR_FREQ: begin
        if (diag_page) begin
          rdata_next[FREQ_SEL] = freq_sel_reg[FREQ_SEL];
          if (diag_valid) begin
            rdata_next[7:0] = freq_sel_reg[FREQ_SEL] ? line_in.freq_ctl : line_in.freq_off;
          end
        end
      end
      ADDR_TENSC: begin
        if (diag_page) begin
          rdata_next = variance_control_reg;
        end else begin
          rdata_next[TEN_POL] = sts_word[STS_POL];
        end
      end
      ADDR_VDAT: begin
        if (diag_page) begin
          rdata_next = var_half_reg ? var_snap_reg[31:16] : var_sum_reg[15:0];
        end
      end
      ADDR_EDC: begin
        if (!diag_page) begin
          rdata_next = energy_detect_control_reg;
        end
      end
      default: rdata_next = 16'h0;
    endcase
  end

  // register reads served in every power state
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 16'h0;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rdata_next;
    end
  end

  // MII datapath
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      mii_rx_out   <= '0;
      mii_oe_out   <= 1'b0;
      media_tx_out <= '0;
    end else begin
      mii_oe_out <= !basic_mode_control_reg[BMC_ISO];
      // loopback to receive, same in either duplex
      mii_rx_out <= basic_mode_control_reg[BMC_LOOP] ? mii_tx_in : line_rx_in;
      // no media data in loopback, isolate or power-down
      if (basic_mode_control_reg[BMC_LOOP] || basic_mode_control_reg[BMC_ISO] || pdn) begin
        media_tx_out <= '0;
      end else begin
        media_tx_out <= mii_tx_in;
      end
    end
  end

  // Carrier and collision reporting
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      mii_crs_out <= 1'b0;
      mii_col_out <= 1'b0;
    end else if (full_duplex) begin
      mii_crs_out <= basic_mode_control_reg[BMC_LOOP] ? mii_tx_in.en : line_rx_in.en;
      mii_col_out <= 1'b0;
    end else begin
      mii_crs_out <= mii_tx_in.en || line_rx_in.en;
      mii_col_out <= line_col_in && !basic_mode_control_reg[BMC_LOOP];
    end
  end

endmodule : pdl_mode_status

// file: src/pdl_pkg.sv
package pdl_pkg;
  // Register indices
  localparam logic [4:0] ADDR_BMC    = 5'h00;
  localparam logic [4:0] ADDR_STS    = 5'h10;
  localparam logic [4:0] ADDR_ICTL   = 5'h11;
  localparam logic [4:0] ADDR_IMS    = 5'h12;
  localparam logic [4:0] ADDR_PAGE   = 5'h13;
  localparam logic [4:0] ADDR_CLEN   = 5'h14;
  localparam logic [4:0] ADDR_FREQ   = 5'h15;
  localparam logic [4:0] ADDR_TENSC  = 5'h1a;
  localparam logic [4:0] ADDR_VCTL   = 5'h1a;
  localparam logic [4:0] ADDR_VDAT   = 5'h1b;
  localparam logic [4:0] ADDR_EDC    = 5'h1d;
  localparam logic [2:0] DIAG_PAGE   = 3'h2;
  // Basic mode control fields
  localparam int BMC_LOOP   = 14;
  localparam int BMC_SPEED  = 13;
  localparam int BMC_NEGOTIATION_ENABLE_STRAP  = 12;
  localparam int BMC_PDN    = 11;
  localparam int BMC_ISO    = 10;
  localparam int BMC_DUPLEX = 8;
  localparam logic [15:0] BMC_RESET = 16'h3000;
  // Status fields
  localparam int STS_LINK   = 0;
  localparam int STS_SPD10  = 1;
  localparam int STS_DUPLEX = 2;
  localparam int STS_LOOP   = 3;
  localparam int STS_POL    = 12;
  localparam int STS_MDIX   = 14;
  localparam int TEN_POL    = 4;
  // Interrupt control and sources
  localparam int ICTL_OE    = 0;
  localparam int ICTL_EN    = 1;
  localparam int SRC_SPEED  = 3;
  localparam int SRC_DUPLEX = 4;
  localparam int SRC_LINK   = 5;
  localparam int SRC_ENERGY = 6;
  localparam int PEND_LSB   = 8;
  // Energy detect, frequency and variance controls
  localparam int EDC_EN     = 15;
  localparam int FREQ_SEL   = 8;
  localparam int VCTL_EN    = 15;
  localparam int VCTL_T_LSB = 1;
  localparam int CLK_MHZ    = 100;
  localparam int VAR_STEP_MS       = 2;
  localparam int ED_PULSE_PERIOD_US = 1000;
  localparam int ED_PULSE_CYCLES    = ED_PULSE_PERIOD_US * CLK_MHZ;
  localparam int VAR_STEP_CYCLES    = VAR_STEP_MS * 1000 * CLK_MHZ;

  typedef struct packed {
    logic       en;
    logic       er;
    logic [3:0] d;
  } pdl_mii_s;

  typedef struct packed {
    logic        speed_100;
    logic        link_up;
    logic        an_done;
    logic        an_full;
    logic        pol_inv;
    logic        mdix;
    logic        energy;
    logic [15:0] cable_len;
    logic [7:0]  freq_off;
    logic [7:0]  freq_ctl;
  } pdl_line_s;
endpackage : pdl_pkg
